// *** lfp_map.svh ***
// lfp_map.svh: named figures for the led fade pwm block
// assumes inclusion by bare name from the package and the design file
`ifndef LFP_MAP_SVH
`define LFP_MAP_SVH

`define LFP_NUM_CHAN      16
`define LFP_NUM_TMR       8
`define LFP_TMR_W         20
`define LFP_FADE_W        10
`define LFP_BUS_CLK_MHZ   80
`define LFP_OSC_CLK_MHZ   8
`define LFP_OSC_DIV       (`LFP_BUS_CLK_MHZ / `LFP_OSC_CLK_MHZ)
`define LFP_DIV_W         4
`define LFP_FINE_RES_BITS 16
`define LFP_FINE_PERIOD_US 1000
`define LFP_DUTY_RST      20'h00000
`define LFP_CNT_ZERO      20'h00000
`define LFP_CNT_ONE       20'h00001
`define LFP_FADE_ZERO     10'h000
`define LFP_FADE_ONE      10'h001
`define LFP_DIV_ZERO      4'h0
`define LFP_DIV_ONE       4'h1

`endif

// *** lfp_pkg.sv ***
// lfp_pkg: shared types of the led fade pwm block
// assumes lfp_map.svh is on the include path
`include "lfp_map.svh"

package lfp_pkg;

   typedef logic [`LFP_TMR_W-1:0] lfp_cnt_t;

   typedef enum logic {
      LFP_FADE_UP   = 1'b0,
      LFP_FADE_DOWN = 1'b1
   } lfp_fade_dir_e;

endpackage

// *** lfp_led_fade_pwm.sv ***
// lfp_led_fade_pwm: sixteen-channel led pwm with shared timers and duty fading
// assumes every control input is driven by logic on i_sys_clk
`timescale 1ns/100ps
`default_nettype none
`include "lfp_map.svh"

module lfp_led_fade_pwm #(
   parameter int NUM_CHAN = `LFP_NUM_CHAN,
   parameter int NUM_TMR  = `LFP_NUM_TMR,
   parameter int TMR_W    = `LFP_TMR_W,
   parameter int FADE_W   = `LFP_FADE_W,
   parameter int OSC_DIV  = `LFP_OSC_DIV
) (
   input  wire logic                        i_sys_clk,
   input  wire logic                        i_rst,
   input  wire logic [NUM_TMR-1:0]          i_tmr_en,
   input  wire logic [NUM_TMR/2-1:0]        i_tmr_osc_sel,
   input  wire logic [NUM_TMR*TMR_W-1:0]    i_tmr_range,
   input  wire logic [NUM_CHAN-1:0]         i_chan_en,
   input  wire logic [NUM_CHAN*$clog2(NUM_TMR/2)-1:0] i_chan_tmr,
   input  wire logic [NUM_CHAN-1:0]         i_duty_wr,
   input  wire logic [TMR_W-1:0]            i_duty_wdata,
   input  wire logic [NUM_CHAN-1:0]         i_fade_start,
   input  wire logic [NUM_CHAN-1:0]         i_fade_stop,
   input  wire logic                        i_fade_dir,
   input  wire logic [TMR_W-1:0]            i_fade_step,
   input  wire logic [FADE_W-1:0]           i_fade_num,
   input  wire logic [FADE_W-1:0]           i_fade_cycles,
   output logic      [NUM_CHAN-1:0]         o_chan,
   output logic      [NUM_CHAN-1:0]         o_fade_busy
);

   localparam int TSEL_W = $clog2(NUM_TMR/2);
   localparam logic [`LFP_DIV_W-1:0] OSC_LAST = `LFP_DIV_W'(OSC_DIV - 1);

   // ************************************************************
   // oscillator-rate tick
   // ************************************************************
   // the 8 MHz source is modelled as an enable pulse every OSC_DIV bus cycles
   // a ratio that is not whole would need a fractional divider; not offered
   logic [`LFP_DIV_W-1:0] osc_div_r;
   logic                  osc_tick_r;

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         osc_div_r  <= `LFP_DIV_ZERO;
         osc_tick_r <= 1'b0;
      end else if (osc_div_r == OSC_LAST) begin
         osc_div_r  <= `LFP_DIV_ZERO;
         osc_tick_r <= 1'b1;
      end else begin
         osc_div_r  <= osc_div_r + `LFP_DIV_ONE;
         osc_tick_r <= 1'b0;
      end
   end

   // ************************************************************
   // shared timers
   // ************************************************************
   // lower half of the timers serves the low-speed channel group and may
   // run from the oscillator; upper half always runs from the bus clock
   lfp_pkg::lfp_cnt_t     tmr_cnt_r [NUM_TMR];
   logic [NUM_TMR-1:0]    tmr_tick;
   logic [NUM_TMR-1:0]    tmr_last;
   logic [NUM_TMR-1:0]    tmr_wrap;

   always_comb begin
      for (int t = 0; t < NUM_TMR; t++) begin
         tmr_tick[t] = i_tmr_en[t];
         if (t < NUM_TMR/2) begin
            // modulo keeps the index legal for upper timers, which never get here
            if (i_tmr_osc_sel[t % (NUM_TMR/2)]) begin
               tmr_tick[t] = i_tmr_en[t] & osc_tick_r;
            end
         end
         // a range of zero behaves as one so the timer never runs away
         // >= rather than == so a range cut below the count wraps at once
         tmr_last[t] = (i_tmr_range[t*TMR_W +: TMR_W] == `LFP_CNT_ZERO) ||
                       (tmr_cnt_r[t] >= i_tmr_range[t*TMR_W +: TMR_W] - `LFP_CNT_ONE);
         tmr_wrap[t] = tmr_tick[t] & tmr_last[t];
      end
   end

   // a disabled timer is held at zero so it restarts cleanly when enabled
   always_ff @(posedge i_sys_clk) begin
      for (int t = 0; t < NUM_TMR; t++) begin
         if (i_rst || !i_tmr_en[t]) begin
            tmr_cnt_r[t] <= `LFP_CNT_ZERO;
         end else if (tmr_tick[t]) begin
            if (tmr_last[t]) begin
               tmr_cnt_r[t] <= `LFP_CNT_ZERO;
            end else begin
               tmr_cnt_r[t] <= tmr_cnt_r[t] + `LFP_CNT_ONE;
            end
         end
      end
   end

   // ************************************************************
   // channel to timer routing
   // ************************************************************
   // channels 0..7 reach timers 0..3, channels 8..15 timers 4..7;
   // only the lower group can run from the oscillator, which keeps the
   // select field two bits wide at the cost of a fixed split
   lfp_pkg::lfp_cnt_t     ch_cnt [NUM_CHAN];
   logic [NUM_CHAN-1:0]   ch_wrap;
   logic [NUM_CHAN-1:0]   ch_run;

   always_comb begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         int idx;
         idx = int'(i_chan_tmr[c*TSEL_W +: TSEL_W]);
         if (c >= NUM_CHAN/2) begin
            idx = idx + NUM_TMR/2;
         end
         ch_cnt[c]  = tmr_cnt_r[idx];
         ch_wrap[c] = tmr_wrap[idx];
         ch_run[c]  = i_tmr_en[idx];
      end
   end

   // ************************************************************
   // duty and fading
   // ************************************************************
   lfp_pkg::lfp_cnt_t       duty_r     [NUM_CHAN];
   lfp_pkg::lfp_cnt_t       step_r     [NUM_CHAN];
   logic [FADE_W-1:0]       steps_r    [NUM_CHAN];
   logic [FADE_W-1:0]       cycles_r   [NUM_CHAN];
   logic [FADE_W-1:0]       cyc_cnt_r  [NUM_CHAN];
   lfp_pkg::lfp_fade_dir_e  dir_r      [NUM_CHAN];
   lfp_pkg::lfp_cnt_t       duty_nxt   [NUM_CHAN];
   logic [NUM_CHAN-1:0]     step_due;

   always_comb begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         logic [TMR_W:0] sum;
         sum = {1'b0, duty_r[c]} + {1'b0, step_r[c]};
         if (dir_r[c] == lfp_pkg::LFP_FADE_UP) begin
            // saturate instead of wrapping so a fade never flashes
            duty_nxt[c] = sum[TMR_W] ? {TMR_W{1'b1}} : sum[TMR_W-1:0];
         end else begin
            duty_nxt[c] = (duty_r[c] < step_r[c]) ? `LFP_CNT_ZERO : duty_r[c] - step_r[c];
         end
         step_due[c] = (cycles_r[c] <= `LFP_FADE_ONE) || (cyc_cnt_r[c] >= cycles_r[c] - `LFP_FADE_ONE);
      end
   end

   // fade settings are latched at start, so the shared inputs may change mid-fade
   always_ff @(posedge i_sys_clk) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (i_rst) begin
            duty_r[c]    <= `LFP_DUTY_RST;
            step_r[c]    <= `LFP_CNT_ZERO;
            steps_r[c]   <= `LFP_FADE_ZERO;
            cycles_r[c]  <= `LFP_FADE_ZERO;
            cyc_cnt_r[c] <= `LFP_FADE_ZERO;
            dir_r[c]     <= lfp_pkg::LFP_FADE_UP;
         end else if (i_duty_wr[c]) begin
            duty_r[c]    <= i_duty_wdata;
         end else if (i_fade_stop[c]) begin
            // a stop freezes the duty where the fade left it
            duty_r[c]    <= duty_r[c];
         end else if (i_fade_start[c]) begin
            step_r[c]    <= i_fade_step;
            steps_r[c]   <= i_fade_num;
            cycles_r[c]  <= i_fade_cycles;
            cyc_cnt_r[c] <= `LFP_FADE_ZERO;
            dir_r[c]     <= lfp_pkg::lfp_fade_dir_e'(i_fade_dir);
         end else if (o_fade_busy[c] && ch_wrap[c]) begin
            if (step_due[c]) begin
               cyc_cnt_r[c] <= `LFP_FADE_ZERO;
               duty_r[c]    <= duty_nxt[c];
               steps_r[c]   <= steps_r[c] - `LFP_FADE_ONE;
            end else begin
               cyc_cnt_r[c] <= cyc_cnt_r[c] + `LFP_FADE_ONE;
            end
         end
      end
   end

   // ************************************************************
   // fade activity flag
   // ************************************************************
   // a direct write or a stop beats a start in the same cycle, so
   // software intervention is never undone by a stale start strobe
   always_ff @(posedge i_sys_clk) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (i_rst) begin
            o_fade_busy[c] <= 1'b0;
         end else if (i_duty_wr[c] || i_fade_stop[c]) begin
            o_fade_busy[c] <= 1'b0;
         end else if (i_fade_start[c]) begin
            o_fade_busy[c] <= (i_fade_num != `LFP_FADE_ZERO);
         end else if (o_fade_busy[c] && ch_wrap[c] && step_due[c] && (steps_r[c] == `LFP_FADE_ONE)) begin
            o_fade_busy[c] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // waveform outputs
   // ************************************************************
   // full 20-bit compare; at an 8 MHz tick a 1 ms period gives about
   // 13 bits, the 16-bit figure needs the full-rate 80 MHz clock
   always_ff @(posedge i_sys_clk) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (i_rst) begin
            o_chan[c] <= 1'b0;
         end else begin
            o_chan[c] <= i_chan_en[c] & ch_run[c] & (ch_cnt[c] < duty_r[c]);
         end
      end
   end

endmodule
`default_nettype wire

// *** lfp_checker.sv ***
// lfp_checker: strobe to output relations of the led pwm block
// assumes a bind onto lfp_led_fade_pwm at its default widths
`timescale 1ns/100ps
`default_nettype none
module lfp_checker (
   input wire logic        i_sys_clk,
   input wire logic        i_rst,
   input wire logic [7:0]  i_tmr_en,
   input wire logic [15:0] i_chan_en,
   input wire logic [15:0] i_duty_wr,
   input wire logic [19:0] i_duty_wdata,
   input wire logic [15:0] i_fade_start,
   input wire logic [15:0] i_fade_stop,
   input wire logic [15:0] o_chan,
   input wire logic [15:0] o_fade_busy
);
   //********************
   // properties
   //********************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_off; (o_chan & ~$past(i_chan_en)) == 16'h0000; endproperty
   a_off: assert property (p_off) else $error("output on a disabled channel");
   property p_tmr; i_tmr_en == 8'h00 |=> o_chan == 16'h0000; endproperty
   a_tmr: assert property (p_tmr) else $error("output with timers stopped");
   // duty zero shows two edges on: load, then registered compare
   property p_dz;
      i_duty_wr != 16'h0000 && i_duty_wdata == 20'h00000 |=> ##1 (o_chan & $past(i_duty_wr, 2)) == 16'h0000;
   endproperty
   a_dz: assert property (p_dz) else $error("zero duty still drives output");
   property p_wr; i_duty_wr != 16'h0000 |=> (o_fade_busy & $past(i_duty_wr)) == 16'h0000; endproperty
   a_wr: assert property (p_wr) else $error("fade survives a duty write");
   property p_stop; i_fade_stop != 16'h0000 |=> (o_fade_busy & $past(i_fade_stop)) == 16'h0000; endproperty
   a_stop: assert property (p_stop) else $error("fade survives a stop");
   property p_rise; (o_fade_busy & ~$past(o_fade_busy) & ~$past(i_fade_start)) == 16'h0000; endproperty
   a_rise: assert property (p_rise) else $error("fade began without start");
endmodule
bind lfp_led_fade_pwm lfp_checker i_chk (.*);
`default_nettype wire

// *** lfp_led_model.sv ***
// lfp_led_model: led load reporting each on-time in clock cycles
// assumes the led line changes just after the rising clock edge
`timescale 1ns/100ps
`default_nettype none
module lfp_led_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_led,
   output logic      [15:0] o_width,
   output logic             o_done
);
   //********************
   // on-time meter
   //********************
   always_ff @(posedge i_sys_clk)
      o_width <= i_led ? o_width + 16'h0001 : 16'h0000;
   // width holds only in the one cycle after the led goes dark
   assign o_done = !i_led && o_width != 16'h0000;
endmodule
`default_nettype wire

// *** testbench.sv ***
// testbench: drives the pwm block and scores led on-times
// assumes lfp_led_model and lfp_checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
   //********************
   // stimulus and scoring
   //********************
   logic         clk = 1'b0, rst = 1'b1, arm = 1'b0, fdr = 1'b0, dn;
   logic [7:0]   ten = 8'hff;
   logic [3:0]   osc = 4'h0;
   logic [159:0] rng = {8{20'h00010}};
   logic [15:0]  cen = 16'hffff, oc, fb, wd, q[$];
   logic [47:0]  stb = 48'h0;
   logic [31:0]  ctm = 32'h0, s = 32'h3d;
   logic [19:0]  dwd = 20'h00000;
   logic [9:0]   fnm = 10'h003;
   int           fail_count = 0, n_tests = 0, c = 0, t = 0, r, d, dv;
   lfp_led_model i_led (.i_sys_clk(clk), .i_led(oc[c]), .o_width(wd), .o_done(dn));
   lfp_led_fade_pwm #(.OSC_DIV(3)) i_dut (.i_sys_clk(clk), .i_rst(rst), .i_tmr_en(ten), .i_tmr_osc_sel(osc),
      .i_tmr_range(rng), .i_chan_en(cen), .i_chan_tmr(ctm), .i_duty_wr(stb[15:0]), .i_duty_wdata(dwd),
      .i_fade_start(stb[47:32]), .i_fade_stop(stb[31:16]), .i_fade_dir(fdr), .i_fade_step(20'h00002),
      .i_fade_num(fnm), .i_fade_cycles(10'h002), .o_chan(oc), .o_fade_busy(fb));
   function logic [31:0] rnd();
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task end_of_test();
      $display("compares %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // strobes: bit 2 fade start, bit 1 fade stop, bit 0 duty write
   task go(input logic [2:0] m);
      @(negedge clk);
      stb = {{16{m[2]}}, {16{m[1]}}, {16{m[0]}}} & {3{16'h0001 << c}};
      @(negedge clk);
      stb = 48'h0;
   endtask
   // timer held at zero two cycles so a shorter range cannot strand it
   task cfg(input int rr, input logic [19:0] dd);
      ten[t] = 1'b0;
      rng[t*20+:20] = rr[19:0];
      dwd = dd;
      go(3'b001);
      ten[t] = 1'b1;
      repeat (6 * rr) @(negedge clk);
   endtask
   task expect_on(input int n, input logic [15:0] w);
      for (int i = 0; i < 400 && fb[c] === 1'b1; i++) @(negedge clk);
      if (fb[c] !== 1'b0) begin
         fail_count++;
         end_of_test();
      end
      repeat (n) q.push_back(w);
      arm = 1'b1;
      for (int i = 0; i < 3000 && q.size() > 0; i++) @(negedge clk);
      arm = 1'b0;
      $display("case on channel %0d done", c);
      if (q.size() > 0) begin
         fail_count++;
         end_of_test();
      end
   endtask
   always @(negedge clk) if (dn && arm && q.size() > 0) chk(wd, q.pop_front());
   initial forever #50 clk = ~clk;
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      for (int k = 0; k < 8; k++) begin
         c = rnd() % 16;
         t = rnd() % 4;
         ctm[c*2+:2] = t[1:0];
         t = t + 4 * (c / 8);
         r = 4 + rnd() % 28;
         d = 1 + rnd() % (r - 1);
         dv = (t < 4 && rnd() % 2) ? 3 : 1;
         if (t < 4) osc[t] = dv[1];
         cfg(r, d[19:0]);
         expect_on(3, 16'(d * dv));
      end
      osc = 4'h0;
      cfg(16, 20'h00004);
      go(3'b100);
      chk(fb[c], 1'b1);
      expect_on(3, 16'h000a);
      fdr = 1'b1;
      go(3'b100);
      expect_on(3, 16'h0004);
      go(3'b100);
      go(3'b010);
      chk(fb[c], 1'b0);
      fnm = 10'h000;
      go(3'b100);
      chk(fb[c], 1'b0);
      fnm = 10'h003;
      go(3'b100);
      dwd = 20'h00000;
      go(3'b001);
      chk(fb[c], 1'b0);
      $display("case fade strobes done");
      cen = 16'h0000;
      repeat (40) @(negedge clk);
      chk(oc, 16'h0000);
      {cen, ten} = {16'hffff, 8'h00};
      repeat (40) @(negedge clk);
      chk(oc, 16'h0000);
      $display("case output gating done");
      end_of_test();
   end
endmodule
`default_nettype wire
